// [smcr_bank_if.sv]
`timescale 1ns/1ns
interface smcr_bank_if;
	logic wrEn;
	logic [31:0] wrData;
	logic strapLoad;
	logic [1:0] strapWidth;
	logic wpErrSet;
	logic [31:0] value;

	modport ctrl (
		output wrEn,
		output wrData,
		output strapLoad,
		output strapWidth,
		output wpErrSet,
		input value
	);
	modport bank (
		input wrEn,
		input wrData,
		input strapLoad,
		input strapWidth,
		input wpErrSet,
		output value
	);
endinterface : smcr_bank_if

// [smcr_bank_reg.sv]
`timescale 1ns/1ns
module smcr_bank_reg #(
	parameter logic BYTE_LANE_ENABLE_RESET = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register access
	smcr_bank_if.bank bus
);
	logic [31:0] val_q;
	logic [31:0] val_d;
	logic [31:0] wpErrBits;
	logic [31:0] written;
	logic [31:0] kept;

	// Error flag set wins over the clear caused by any write
	assign wpErrBits = {31'h0000_0000, bus.wpErrSet} << smcr_pkg::WPERR_BIT;
	// Reserved bits never stored
	assign written = bus.wrData & smcr_pkg::BANK_WR_MASK; // RQ5
	assign kept = bus.strapLoad
		? {val_q[31:smcr_pkg::MW_HI+1], bus.strapWidth, val_q[smcr_pkg::MW_LO-1:0]} // RQ8
		: val_q;
	assign val_d = (bus.wrEn ? written : kept) | wpErrBits; // RQ6
	assign bus.value = val_q; // RQ10

	always_ff @(posedge clk) begin
		if (!resetn) begin
			val_q <= smcr_pkg::BANK_RESET | ({31'h0000_0000, BYTE_LANE_ENABLE_RESET} << smcr_pkg::BYTE_LANE_ENABLE_BIT); // RQ11
		end else begin
			val_q <= val_d;
		end
	end

	a_reserved_read_zero: assert property (@(posedge clk) disable iff (!resetn) // RQ5
		(bus.value & smcr_pkg::BANK_RESV_MASK) == 32'h0000_0000)
		else $error("reserved bank bits not zero");

	a_wperr_set_wins: assert property (@(posedge clk) disable iff (!resetn)
		bus.wpErrSet |=> bus.value[smcr_pkg::WPERR_BIT])
		else $error("write protect error flag lost");

	a_width_write_held: assert property (@(posedge clk) disable iff (!resetn) // RQ6
		bus.wrEn && !bus.strapLoad |=>
		bus.value[smcr_pkg::MW_HI:smcr_pkg::MW_LO] == $past(bus.wrData[smcr_pkg::MW_HI:smcr_pkg::MW_LO]))
		else $error("memory width write not taken");
endmodule : smcr_bank_reg

// [smcr_pkg.sv]
package smcr_pkg;
	// Register bank geometry
	localparam int BANKS = 6;
	localparam int CARDS = 7;
	localparam logic [31:0] BASE_ADDR = 32'h8000_2000;
	localparam logic [7:0] BANK_OFF [BANKS] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c};
	localparam logic [7:0] CARD_OFF [CARDS] = '{8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h40};

	// Bank configuration field positions
	localparam int MW_HI = 29;
	localparam int MW_LO = 28;
	localparam int WPERR_BIT = 25;
	localparam int BYTE_LANE_ENABLE_BIT = 10;
	localparam logic [31:0] BANK_WR_MASK = 32'h3c00_ffef;
	localparam logic [31:0] BANK_RESV_MASK = 32'hc1ff_0010;
	localparam logic [31:0] BANK_RESET = 32'h0000_fbe0;

	// Memory width codes
	localparam logic [1:0] MW_8BIT = 2'h0;
	localparam logic [1:0] MW_16BIT = 2'h1;
	localparam logic [1:0] MW_32BIT = 2'h2;
	localparam logic [1:0] MW_RESET = MW_8BIT;

	localparam logic [31:0] CARD_RESET = 32'h0000_0000;
endpackage : smcr_pkg

// [smcr_regs.sv]
`timescale 1ns/1ns
// What this block does
// RQ1: Registers decode at offsets added to a fixed base address.
// RQ2: Bank 0-3 configs at 0x00-0x0c, banks 6 and 7 at 0x18, 0x1c.
// RQ3: Card 1 at 0x20-0x28, card 2 at 0x30-0x38, slot control 0x40.
// RQ4: Each bank config drives exactly its own chip select.
// RQ5: Bank config bits 31:30 read zero and keep no written value.
// RQ6: Width field 29:28 codes 00, 01, 10 give 8, 16, 32 bits.
// RQ7: Software never writes width code 11; result is unpredictable.
// RQ8: Select pin low after reset loads bank 0 width from the straps.
// RQ9: Board keeps one strap low when booting from chip select 0.
// RQ10: Width field reads back the value in force, strap value included.
// RQ11: Byte lane enable resets to one in bank 0, zero elsewhere.
// RQ12: Unmapped offsets read zero and writes there change nothing.
module smcr_regs #(
	parameter logic [31:0] BASE = smcr_pkg::BASE_ADDR
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	// Boot width straps
	input wire logic bootWidthSelectPinN,
	input wire logic bootWidthStrapHi,
	input wire logic bootWidthStrapLo,
	// Write protect events, one per bank in order 0,1,2,3,6,7
	input wire logic [smcr_pkg::BANKS-1:0] wpErrEvent,
	// Chip select configuration, one word per bank in order 0,1,2,3,6,7
	output logic [smcr_pkg::BANKS*32-1:0] bankConfig,
	// Card slot configuration
	output logic [31:0] card1AttributeTiming,
	output logic [31:0] card1CommonTiming,
	output logic [31:0] card1IoTiming,
	output logic [31:0] card2AttributeTiming,
	output logic [31:0] card2CommonTiming,
	output logic [31:0] card2IoTiming,
	output logic [31:0] cardSlotControl
);
	localparam int BANKS = smcr_pkg::BANKS;
	localparam int CARDS = smcr_pkg::CARDS;

	// Matches a full bus address against a register offset in this block
	function automatic logic addrHits(input logic [31:0] addr, input logic [7:0] off);
		addrHits = (addr[31:8] == BASE[31:8]) && (addr[7:0] == off);
	endfunction : addrHits

	logic pready_q;
	logic [31:0] prdata_q;
	logic strapDone_q;
	logic [31:0] card_q [CARDS];
	logic [31:0] bankValue [BANKS];
	logic [BANKS-1:0] bankHit;
	logic [CARDS-1:0] cardHit;
	logic setupPhase;
	logic commit;
	logic anyHit;
	logic strapLoad;
	logic [31:0] readData;

	smcr_bank_if bankBus [BANKS] ();

	assign setupPhase = psel && !penable;
	// Write takes effect at the access edge where pready is seen high
	assign commit = psel && penable && pready_q && pwrite;
	assign anyHit = (|bankHit) || (|cardHit);
	// Strap capture on the first clock after reset release
	assign strapLoad = resetn && !strapDone_q && !bootWidthSelectPinN; // RQ8

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : gBank
			assign bankHit[g] = addrHits(paddr, smcr_pkg::BANK_OFF[g]); // RQ1 RQ2
			assign bankBus[g].wrEn = commit && bankHit[g];
			assign bankBus[g].wrData = pwdata;
			assign bankBus[g].strapLoad = (g == 0) ? strapLoad : 1'b0; // RQ8
			assign bankBus[g].strapWidth = {bootWidthStrapHi, bootWidthStrapLo};
			assign bankBus[g].wpErrSet = wpErrEvent[g];
			assign bankValue[g] = bankBus[g].value;
			// Each bank drives only its own chip select word
			assign bankConfig[g*32 +: 32] = bankBus[g].value; // RQ4

			smcr_bank_reg #(
				.BYTE_LANE_ENABLE_RESET(g == 0) // RQ11
			) uBank (
				.clk(clk),
				.resetn(resetn),
				.bus(bankBus[g])
			);
		end
		for (g = 0; g < CARDS; g++) begin : gCard
			assign cardHit[g] = addrHits(paddr, smcr_pkg::CARD_OFF[g]); // RQ1 RQ3
		end
	endgenerate

	// Card words live in one process so the array has a single driver
	always_ff @(posedge clk) begin
		for (int i = 0; i < CARDS; i++) begin
			if (!resetn) begin
				card_q[i] <= smcr_pkg::CARD_RESET;
			end else if (commit && cardHit[i]) begin
				card_q[i] <= pwdata;
			end
		end
	end

	// Read mux; unmapped offsets fall through to zero
	always_comb begin
		readData = 32'h0000_0000; // RQ12
		for (int i = 0; i < BANKS; i++) begin
			readData = readData | (bankHit[i] ? bankValue[i] : 32'h0000_0000);
		end
		for (int i = 0; i < CARDS; i++) begin
			readData = readData | (cardHit[i] ? card_q[i] : 32'h0000_0000);
		end
	end

	// One-cycle access phase: answer is prepared during setup
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setupPhase;
			prdata_q <= (setupPhase && !pwrite) ? readData : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			strapDone_q <= 1'b0;
		end else begin
			strapDone_q <= 1'b1;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign card1AttributeTiming = card_q[0];
	assign card1CommonTiming = card_q[1];
	assign card1IoTiming = card_q[2];
	assign card2AttributeTiming = card_q[3];
	assign card2CommonTiming = card_q[4];
	assign card2IoTiming = card_q[5];
	assign cardSlotControl = card_q[6];

	a_pready_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
		setupPhase |=> pready ##1 !pready || (psel && !penable))
		else $error("pready not a single access cycle");

	a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!resetn) // RQ12
		setupPhase && !pwrite && !anyHit |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_unmapped_write_none: assert property (@(posedge clk) disable iff (!resetn) // RQ12
		commit && !anyHit |=> $stable(card_q[6]) && $stable(bankConfig[31:0]))
		else $error("unmapped write changed a register");

	a_byte_lane_enable_reset_value: assert property (@(posedge clk) // RQ11
		!resetn |=> bankConfig[smcr_pkg::BYTE_LANE_ENABLE_BIT] && !bankConfig[32+smcr_pkg::BYTE_LANE_ENABLE_BIT]
		&& !bankConfig[4*32+smcr_pkg::BYTE_LANE_ENABLE_BIT])
		else $error("byte lane enable reset value wrong");

	a_strap_capture: assert property (@(posedge clk) disable iff (!resetn) // RQ8
		strapLoad |=> bankConfig[smcr_pkg::MW_HI:smcr_pkg::MW_LO]
		== $past({bootWidthStrapHi, bootWidthStrapLo}))
		else $error("boot width not captured into bank 0");

	a_bank6_offset: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		commit && paddr == (BASE | 32'h0000_0018) |=>
		bankConfig[4*32+3:4*32] == $past(pwdata[3:0]))
		else $error("bank 6 write at its offset not taken");

	a_slot_ctrl_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0040) |=> cardSlotControl == $past(pwdata))
		else $error("card slot control write not taken");

	a_bank_read_back: assert property (@(posedge clk) disable iff (!resetn) // RQ10
		setupPhase && !pwrite && bankHit[0] |=> prdata == $past(bankConfig[31:0]))
		else $error("bank 0 read does not return its value");

	a_idle_no_ready: assert property (@(posedge clk) disable iff (!resetn)
		!setupPhase |=> !pready)
		else $error("pready without a setup cycle");

	a_access_ready: assert property (@(posedge clk) disable iff (!resetn)
		setupPhase |=> pready)
		else $error("pready missing after setup");

	a_write_prdata_zero: assert property (@(posedge clk) disable iff (!resetn)
		setupPhase && pwrite |=> prdata == 32'h0000_0000)
		else $error("read data shown during a write");

	a_idle_prdata_zero: assert property (@(posedge clk) disable iff (!resetn)
		!setupPhase |=> prdata == 32'h0000_0000)
		else $error("read data shown outside an access");

	a_card_reset_zero: assert property (@(posedge clk)
		!resetn |=> {card1AttributeTiming, card1CommonTiming, card1IoTiming} == 96'h0
		&& {card2AttributeTiming, card2CommonTiming, card2IoTiming, cardSlotControl} == 128'h0)
		else $error("card register reset value wrong");

	a_bank_reset_value: assert property (@(posedge clk) // RQ11
		!resetn |=> bankConfig[63:32] == smcr_pkg::BANK_RESET)
		else $error("bank 1 reset value wrong");

	a_card1_attr_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0020) |=> card1AttributeTiming == $past(pwdata))
		else $error("card 1 attribute write not taken");

	a_card1_com_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0024) |=> card1CommonTiming == $past(pwdata))
		else $error("card 1 common write not taken");

	a_card1_io_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0028) |=> card1IoTiming == $past(pwdata))
		else $error("card 1 io write not taken");

	a_card2_attr_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0030) |=> card2AttributeTiming == $past(pwdata))
		else $error("card 2 attribute write not taken");

	a_card2_com_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0034) |=> card2CommonTiming == $past(pwdata))
		else $error("card 2 common write not taken");

	a_card2_io_write: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		commit && paddr == (BASE | 32'h0000_0038) |=> card2IoTiming == $past(pwdata))
		else $error("card 2 io write not taken");

	a_bank0_write: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		commit && paddr == BASE |=>
		bankConfig[15:5] == $past(pwdata[15:5]) && bankConfig[3:0] == $past(pwdata[3:0]))
		else $error("bank 0 write at its offset not taken");

	a_bank1_write: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		commit && paddr == (BASE | 32'h0000_0004) |=> bankConfig[35:32] == $past(pwdata[3:0]))
		else $error("bank 1 write at its offset not taken");

	a_bank2_write: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		commit && paddr == (BASE | 32'h0000_0008) |=> bankConfig[67:64] == $past(pwdata[3:0]))
		else $error("bank 2 write at its offset not taken");

	a_bank3_write: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		commit && paddr == (BASE | 32'h0000_000c) |=> bankConfig[99:96] == $past(pwdata[3:0]))
		else $error("bank 3 write at its offset not taken");

	a_bank7_write: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		commit && paddr == (BASE | 32'h0000_001c) |=> bankConfig[163:160] == $past(pwdata[3:0]))
		else $error("bank 7 write at its offset not taken");

	a_slot_read_back: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		setupPhase && !pwrite && cardHit[6] |=> prdata == $past(cardSlotControl))
		else $error("slot control read does not return its value");

	a_bank6_read_back: assert property (@(posedge clk) disable iff (!resetn) // RQ4
		setupPhase && !pwrite && bankHit[4] |=> prdata == $past(bankConfig[159:128]))
		else $error("bank 6 read does not return its value");

	a_foreign_base_none: assert property (@(posedge clk) disable iff (!resetn) // RQ1
		commit && paddr[31:8] != BASE[31:8] |=> $stable(bankConfig) && $stable(cardSlotControl))
		else $error("write outside the block changed a register");

	a_card_gap_none: assert property (@(posedge clk) disable iff (!resetn) // RQ12
		commit && paddr == (BASE | 32'h0000_002c) |=>
		$stable(card1IoTiming) && $stable(card2AttributeTiming))
		else $error("write to a reserved gap changed a card register");

	a_gap_read_zero: assert property (@(posedge clk) disable iff (!resetn) // RQ12
		setupPhase && !pwrite && paddr == (BASE | 32'h0000_0010) |=> prdata == 32'h0000_0000)
		else $error("reserved bank gap read not zero");
endmodule : smcr_regs

// [tb.sv]
`timescale 1ns/1ns
module tb;
	logic clk, resetn, psel, penable, pwrite, pready, pinN, sHi, sLo;
	logic [31:0] paddr, pwdata, prdata, rdv, d;
	logic [5:0] wpEv;
	logic [191:0] bankCfg;
	logic [31:0] cardOut [0:6];
	logic [31:0] mdl [0:63];
	int kind [0:63];
	int err_total, cmp_count, cyc, i;
	localparam logic [31:0] BASE = smcr_pkg::BASE_ADDR;

	smcr_regs smcr_regs_i (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .bootWidthSelectPinN(pinN), .bootWidthStrapHi(sHi),
		.bootWidthStrapLo(sLo), .wpErrEvent(wpEv), .bankConfig(bankCfg),
		.card1AttributeTiming(cardOut[0]), .card1CommonTiming(cardOut[1]),
		.card1IoTiming(cardOut[2]), .card2AttributeTiming(cardOut[3]),
		.card2CommonTiming(cardOut[4]), .card2IoTiming(cardOut[5]),
		.cardSlotControl(cardOut[6]));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic test_done;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdv = prdata;
		chk({31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : xfer

	task automatic wr(input logic [7:0] off, input logic [31:0] wd);
		xfer(1'b1, BASE + off, wd);
		if (kind[off >> 2] == 1) mdl[off >> 2] = wd & smcr_pkg::BANK_WR_MASK;
		else if (kind[off >> 2] == 2) mdl[off >> 2] = wd;
	endtask : wr

	task automatic rd(input logic [7:0] off);
		xfer(1'b0, BASE + off, 32'h0);
		chk(rdv, mdl[off >> 2]);
	endtask : rd

	task automatic cfg_chk;
		for (int k = 0; k < 6; k++) chk(bankCfg[k*32 +: 32], mdl[smcr_pkg::BANK_OFF[k] >> 2]);
		for (int k = 0; k < 7; k++) chk(cardOut[k], mdl[smcr_pkg::CARD_OFF[k] >> 2]);
	endtask : cfg_chk

	task automatic rst(input logic p, input logic h, input logic l);
		resetn <= 1'b0;
		pinN <= p;
		sHi <= h;
		sLo <= l;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		for (int k = 0; k < 64; k++) mdl[k] = (kind[k] == 1) ? smcr_pkg::BANK_RESET : 32'h0;
		mdl[0] = smcr_pkg::BANK_RESET | 32'h0000_0400 | (p ? 32'h0 : {2'h0, h, l, 28'h0});
	endtask : rst

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		void'($urandom(77892));
		{resetn, psel, penable, pwrite, pinN, sHi, sLo} = 7'h01;
		paddr = 32'h0;
		pwdata = 32'h0;
		wpEv = 6'h0;
		for (i = 0; i < 64; i++) kind[i] = 0;
		for (i = 0; i < 6; i++) kind[smcr_pkg::BANK_OFF[i] >> 2] = 1;
		for (i = 0; i < 7; i++) kind[smcr_pkg::CARD_OFF[i] >> 2] = 2;
		rst(1'b0, 1'b0, 1'b1);
		for (i = 0; i < 17; i++) rd(i * 4);
		rd(8'hfc);
		cfg_chk();
		// Write protect event on bank 2 sets its error flag
		wpEv <= 6'h04;
		@(posedge clk);
		wpEv <= 6'h00;
		mdl[2] = mdl[2] | 32'h0200_0000;
		@(posedge clk);
		rd(8'h08);
		for (i = 0; i < 17; i++) begin
			d = $urandom;
			d[29:28] = 2'(i % 3);
			wr(i * 4, d);
		end
		wr(8'hfc, $urandom);
		for (i = 0; i < 17; i++) rd(i * 4);
		cfg_chk();
		xfer(1'b1, BASE + 32'h100, $urandom);
		rd(8'h00);
		rst(1'b1, 1'b1, 1'b0);
		rd(8'h00);
		rd(8'h04);
		rst(1'b0, 1'b1, 1'b0);
		rd(8'h00);
		test_done();
	end
endmodule : tb
